//--- design/aimrc_consts.vh
/*
 Constants of the motion sensor control register bank: offsets, field
 positions, reset values, state codes and timing counts.
 Assumes inclusion by bare name from the design files.
*/
`ifndef AIMRC_CONSTS_VH
`define AIMRC_CONSTS_VH

`define AIMRC_OFS_DEV_STATUS    8'h05
`define AIMRC_OFS_IRQ_ENABLE    8'h06
`define AIMRC_OFS_OP_MODE       8'h07
`define AIMRC_OFS_SPEED_SEL     8'h08
`define AIMRC_OFS_MOTION_CTRL   8'h09
`define AIMRC_OFS_IRQ_STATUS    8'h14

`define AIMRC_RST_IRQ_ENABLE    8'h00
`define AIMRC_RST_OP_MODE       8'h00
`define AIMRC_RST_SPEED_SEL     8'h00

`define AIMRC_IE_TILT           0
`define AIMRC_IE_FLIP           1
`define AIMRC_IE_ANYM           2
`define AIMRC_IE_SHAKE          3
`define AIMRC_IE_TILT35         4
`define AIMRC_IE_AUTOCLR        6
`define AIMRC_IE_ACQ            7

`define AIMRC_MC_TF_EN          0
`define AIMRC_MC_ANYM_EN        2
`define AIMRC_MC_SHAKE_EN       3
`define AIMRC_MC_TILT35_EN      4

`define AIMRC_MODE_WDT_LOW      4
`define AIMRC_MODE_WDT_HIGH     5
`define AIMRC_ST_SLEEP          2'b00
`define AIMRC_ST_WAKE           2'b01
`define AIMRC_ST_STANDBY        2'b11

`define AIMRC_DS_WDT            4

`define AIMRC_CLK_HZ            25000000
`define AIMRC_WDT_CYCLES        25000

`endif

//--- design/aimrc_ctrl.v
/*
 Control register bank of a 3-axis motion sensor: interrupt source
 enables, clearing policy, operating state, bus watchdog and output
 data rate. Registers are reached through a byte-wide register port
 driven by the serial slave; the serial clock pin is watched here.
 Assumes the motion block supplies raw event conditions and that the
 motion control register byte is presented on motion_ctrl.
*/
`timescale 1ns/1ps
`default_nettype none
`include "aimrc_consts.vh"

module aimrc_ctrl #(
  parameter WDT_CYCLES = `AIMRC_WDT_CYCLES,
  parameter CLK_HZ     = `AIMRC_CLK_HZ
) (
  input  wire       core_clk,
  input  wire       reset,
  input  wire       reg_wr,
  input  wire       reg_rd,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata,
  input  wire [7:0] motion_ctrl,
  input  wire [4:0] motion_event,
  input  wire       serial_clk_pin,
  output reg        slave_idle_req,
  output reg        osc_run,
  output reg  [2:0] osc_rate_code,
  output reg        sample_strobe,
  output reg  [7:0] irq_status,
  output reg        irq_pending
);

  reg [7:0] interrupt_source_enable;
  reg [7:0] operating_mode;
  reg [7:0] sampling_speed_select;
  reg       bus_watchdog_event_flag;
  reg       scl_meta;
  reg       scl_sync;
  reg [31:0] stall_count;
  reg       scl_last;
  reg [4:0] motion_event_q;
  wire      rate_tick;
  wire [1:0] state;
  wire      sampling;
  wire      auto_clear_enable;
  wire      per_sample_irq_enable;
  wire [4:0] src_allowed;
  wire [4:0] src_live;
  wire      stat_wr;
  wire      dev_stat_rd;
  wire      stall_en;
  reg [7:0] next_irq_status;

  assign state                 = operating_mode[1:0];
  assign sampling              = (state == `AIMRC_ST_WAKE);
  assign auto_clear_enable     = interrupt_source_enable[`AIMRC_IE_AUTOCLR];
  assign per_sample_irq_enable = interrupt_source_enable[`AIMRC_IE_ACQ];

  // Per-source gating by enable bit and motion feature bits
  assign src_allowed[0] = interrupt_source_enable[`AIMRC_IE_TILT] &
                          motion_ctrl[`AIMRC_MC_TF_EN];
  assign src_allowed[1] = interrupt_source_enable[`AIMRC_IE_FLIP] &
                          motion_ctrl[`AIMRC_MC_TF_EN];
  assign src_allowed[2] = interrupt_source_enable[`AIMRC_IE_ANYM] &
                          motion_ctrl[`AIMRC_MC_ANYM_EN];
  assign src_allowed[3] = interrupt_source_enable[`AIMRC_IE_SHAKE] &
                          motion_ctrl[`AIMRC_MC_SHAKE_EN] &
                          motion_ctrl[`AIMRC_MC_ANYM_EN];
  assign src_allowed[4] = interrupt_source_enable[`AIMRC_IE_TILT35] &
                          motion_ctrl[`AIMRC_MC_TILT35_EN] &
                          motion_ctrl[`AIMRC_MC_ANYM_EN];
  assign src_live = motion_event_q & src_allowed;

  assign stat_wr     = reg_wr && (reg_addr == `AIMRC_OFS_IRQ_STATUS);
  assign dev_stat_rd = reg_rd && (reg_addr == `AIMRC_OFS_DEV_STATUS);

  // Motion conditions come from the same clock; one register for timing
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      motion_event_q <= 5'h00;
    end else begin
      motion_event_q <= motion_event;
    end
  end

  // Register writes; mode accepted in any state, bits 2,3 kept as written
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      interrupt_source_enable <= `AIMRC_RST_IRQ_ENABLE;
      operating_mode          <= `AIMRC_RST_OP_MODE;
      sampling_speed_select   <= `AIMRC_RST_SPEED_SEL;
    end else if (reg_wr) begin
      case (reg_addr)
        `AIMRC_OFS_IRQ_ENABLE: interrupt_source_enable <= reg_wdata;
        `AIMRC_OFS_OP_MODE:    operating_mode <= reg_wdata;
        `AIMRC_OFS_SPEED_SEL:  sampling_speed_select <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Sample timer runs only in wake; sleep and standby take no samples
  aimrc_rate_timer #(
    .CLK_HZ (CLK_HZ)
  ) u_rate_timer (
    .core_clk  (core_clk),
    .reset     (reset),
    .run       (sampling),
    .rate_code (sampling_speed_select[2:0]),
    .tick      (rate_tick)
  );

  // Status flags; a new event beats a clear in the same cycle
  always @* begin
    next_irq_status = irq_status;
    if (stat_wr) begin
      next_irq_status = 8'h00;
    end
    if (auto_clear_enable) begin
      next_irq_status[4:0] = next_irq_status[4:0] & src_live;
    end
    next_irq_status[4:0] = next_irq_status[4:0] | src_live;
    if (per_sample_irq_enable && rate_tick) begin
      next_irq_status[7] = 1'b1;
    end
    if (!per_sample_irq_enable) begin
      next_irq_status[7] = 1'b0;
    end
    next_irq_status[6:5] = 2'b00;
  end

  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      irq_status  <= 8'h00;
      irq_pending <= 1'b0;
    end else begin
      irq_status  <= next_irq_status;
      irq_pending <= |next_irq_status;
    end
  end

  // Serial clock pin synchroniser
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      scl_meta <= 1'b1;
      scl_sync <= 1'b1;
      scl_last <= 1'b1;
    end else begin
      scl_meta <= serial_clk_pin;
      scl_sync <= scl_meta;
      scl_last <= scl_sync;
    end
  end

  // Stall watchdog: counts while the pin holds a level that is enabled
  assign stall_en = (!scl_sync && operating_mode[`AIMRC_MODE_WDT_LOW]) ||
                    (scl_sync && operating_mode[`AIMRC_MODE_WDT_HIGH]);

  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      stall_count             <= 32'h0;
      slave_idle_req          <= 1'b0;
      bus_watchdog_event_flag <= 1'b0;
    end else begin
      slave_idle_req <= 1'b0;
      // Clear first so that a timeout in the same cycle wins
      if (dev_stat_rd) begin
        bus_watchdog_event_flag <= 1'b0;
      end
      if (!stall_en || (scl_sync != scl_last)) begin
        stall_count <= 32'h0;
      end else if (stall_count >= WDT_CYCLES - 1) begin
        stall_count             <= 32'h0;
        slave_idle_req          <= 1'b1;
        bus_watchdog_event_flag <= 1'b1;
      end else begin
        stall_count <= stall_count + 32'h1;
      end
    end
  end

  // Oscillator follows the rate code and runs outside sleep
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      osc_run       <= 1'b0;
      osc_rate_code <= 3'h0;
      sample_strobe <= 1'b0;
    end else begin
      osc_run       <= (state != `AIMRC_ST_SLEEP);
      osc_rate_code <= sampling_speed_select[2:0];
      sample_strobe <= rate_tick;
    end
  end

  // Read path; unmapped offsets return zero
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `AIMRC_OFS_DEV_STATUS:
          reg_rdata <= {3'b000, bus_watchdog_event_flag, 2'b00, state};
        `AIMRC_OFS_IRQ_ENABLE: reg_rdata <= interrupt_source_enable;
        `AIMRC_OFS_OP_MODE:    reg_rdata <= operating_mode;
        `AIMRC_OFS_SPEED_SEL:  reg_rdata <= sampling_speed_select;
        `AIMRC_OFS_IRQ_STATUS: reg_rdata <= irq_status;
        default:               reg_rdata <= 8'h00;
      endcase
    end
  end

endmodule // aimrc_ctrl
`default_nettype wire

//--- design/aimrc_rate_timer.v
/*
 Sample-period timer: divides the core clock down to the selected
 output data rate and pulses once per sample period.
 Assumes core_clk at the rate given in the constants header.
*/
`timescale 1ns/1ps
`default_nettype none
`include "aimrc_consts.vh"

module aimrc_rate_timer #(
  parameter CLK_HZ = `AIMRC_CLK_HZ
) (
  input  wire       core_clk,
  input  wire       reset,
  input  wire       run,
  input  wire [2:0] rate_code,
  output reg        tick
);

  reg [31:0] count;

  // Core cycles per sample for each rate code
  function [31:0] period_of;
    input [2:0] code;
    begin
      case (code)
        3'h0:    period_of = CLK_HZ / 50;
        3'h1:    period_of = CLK_HZ / 100;
        3'h2:    period_of = CLK_HZ / 125;
        3'h3:    period_of = CLK_HZ / 200;
        3'h4:    period_of = CLK_HZ / 250;
        3'h5:    period_of = CLK_HZ / 500;
        3'h6:    period_of = CLK_HZ / 1000;
        default: period_of = CLK_HZ / 2000;
      endcase
    end
  endfunction

  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      count <= 32'h0;
      tick  <= 1'b0;
    end else if (!run) begin
      count <= 32'h0;
      tick  <= 1'b0;
    end else if (count >= period_of(rate_code) - 32'h1) begin
      count <= 32'h0;
      tick  <= 1'b1;
    end else begin
      count <= count + 32'h1;
      tick  <= 1'b0;
    end
  end

endmodule // aimrc_rate_timer
`default_nettype wire

//--- dv/accel_intr_mode_rate_ctrl_bench.sv
/* Self-checking bench of the control bank; assumes the host model. */
`timescale 1ns/1ps
`default_nettype none
module accel_intr_mode_rate_ctrl_bench;
  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  motion_ctrl = 8'h00;
  logic [4:0]  motion_event = 5'h00;
  logic        serial_clk_pin = 1'b1;
  logic        link_run = 1'b0;
  logic [1:0]  lk = 2'h0;
  logic [7:0]  q;
  wire         reg_wr, reg_rd, slave_idle_req, osc_run, sample_strobe, irq_pending;
  wire  [7:0]  reg_addr, reg_wdata, reg_rdata, irq_status;
  wire  [2:0]  osc_rate_code;
  int          err_count = 0;
  int          check_count = 0;
  int          n;
  int          hits = 0;
  int          hz [8] = '{50, 100, 125, 200, 250, 500, 1000, 2000};
  logic [23:0] rows [4] = '{24'h06C1C1, 24'h070D01, 24'h08050D, 24'h30FF00};
  logic [7:0]  mcs [5] = '{8'h01, 8'h01, 8'h04, 8'h0C, 8'h14};
  aimrc_ctrl #(.WDT_CYCLES(20), .CLK_HZ(200000)) aimrc_ctrl_i (.*);
  aimrc_host aimrc_host_i (.*);
  always #20 core_clk = ~core_clk;
  // Serial clock of 320 ns, frozen between frames
  always @(posedge core_clk) begin
    lk <= lk + 2'h1;
    if (link_run && lk == 2'h3) serial_clk_pin <= ~serial_clk_pin;
    if (slave_idle_req === 1'b1) hits <= hits + 1;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic wait_strobe(output int c);
    c = 0;
    do begin
      @(posedge core_clk);
      c++;
    end while (sample_strobe !== 1'b1 && c < 5000);
  endtask
  task automatic fire(input int s, input logic [7:0] exp);
    motion_event <= 5'(1 << s);
    repeat (3) @(posedge core_clk);
    check(16'(irq_status), 16'(exp));
    check(16'(irq_pending), 16'(|exp));
    motion_event <= 5'h00;
    @(posedge core_clk);
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    reset <= 1'b0;
    for (int a = 6; a <= 8; a++) begin
      aimrc_host_i.rd(8'(a), q);
      check(16'(q), 16'h0000);
    end
    foreach (rows[i]) begin
      aimrc_host_i.wr(rows[i][23:16], rows[i][15:8]);
      aimrc_host_i.rd(rows[i][23:16], q);
      check(16'(q), 16'(rows[i][7:0]));
    end
    for (int r = 0; r < 8; r++) begin
      aimrc_host_i.wr(8'h08, 8'(r));
      wait_strobe(n);
      wait_strobe(n);
      check(16'(n), 16'(200000 / hz[r]));
      check(16'(osc_rate_code), 16'(r));
    end
    aimrc_host_i.wr(8'h07, 8'h03);
    wait_strobe(n);
    check(16'(n), 16'h1388);
    check(16'(osc_run), 16'h0001);
    aimrc_host_i.wr(8'h07, 8'h00);
    repeat (2) @(posedge core_clk);
    check(16'(osc_run), 16'h0000);
    aimrc_host_i.wr(8'h06, 8'h80);
    aimrc_host_i.wr(8'h07, 8'h01);
    wait_strobe(n);
    repeat (2) @(posedge core_clk);
    check(16'(irq_status[7]), 16'h0001);
    aimrc_host_i.wr(8'h06, 8'h00);
    repeat (2) @(posedge core_clk);
    check(16'(irq_status[7]), 16'h0000);
    aimrc_host_i.wr(8'h07, 8'h00);
    for (int s = 0; s < 5; s++) begin
      aimrc_host_i.wr(8'h06, 8'(1 << s));
      motion_ctrl <= mcs[s] & ~((s < 2) ? 8'h01 : 8'h04);
      fire(s, 8'h00);
      motion_ctrl <= mcs[s];
      fire(s, 8'(1 << s));
      repeat (3) @(posedge core_clk);
      check(16'(irq_status), 16'(1 << s));
      aimrc_host_i.wr(8'h14, 8'h00);
      repeat (2) @(posedge core_clk);
      check(16'(irq_status), 16'h0000);
      aimrc_host_i.wr(8'h06, 8'(1 << s) | 8'h40);
      fire(s, 8'(1 << s));
      repeat (3) @(posedge core_clk);
      check(16'(irq_status), 16'h0000);
    end
    serial_clk_pin <= 1'b0;
    repeat (40) @(posedge core_clk);
    check(16'(hits), 16'h0000);
    aimrc_host_i.wr(8'h07, 8'h10);
    repeat (30) @(posedge core_clk);
    link_run <= 1'b1;
    repeat (8) @(posedge core_clk);
    check(16'(hits), 16'h0001);
    aimrc_host_i.rd(8'h05, q);
    check(16'(q), 16'h0010);
    aimrc_host_i.rd(8'h05, q);
    check(16'(q), 16'h0000);
    link_run <= 1'b0;
    @(posedge core_clk);
    serial_clk_pin <= 1'b1;
    aimrc_host_i.wr(8'h07, 8'h20);
    repeat (30) @(posedge core_clk);
    link_run <= 1'b1;
    repeat (8) @(posedge core_clk);
    check(16'(hits), 16'h0002);
    complete_run;
  end
  // About 26k cycles expected, so 2 ms leaves ample margin
  initial begin
    #2000000;
    err_count++;
    complete_run;
  end
endmodule // accel_intr_mode_rate_ctrl_bench
`default_nettype wire

//--- dv/aimrc_ctrl_checker.sv
/* Port checker of the control bank; assumes a bind onto aimrc_ctrl. */
`timescale 1ns/1ps
`default_nettype none
module aimrc_ctrl_checker #(
  parameter WDT_CYCLES = 20,
  parameter CLK_HZ     = 200000
) (
  input wire logic       core_clk,
  input wire logic       reset,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] motion_ctrl,
  input wire logic [4:0] motion_event,
  input wire logic       serial_clk_pin,
  input wire logic       slave_idle_req,
  input wire logic       osc_run,
  input wire logic [2:0] osc_rate_code,
  input wire logic       sample_strobe,
  input wire logic [7:0] irq_status,
  input wire logic       irq_pending
);
  logic [7:0] ie_s;
  logic [7:0] md_s;
  logic [7:0] sr_s;
  wire        wr14 = reg_wr && reg_addr == 8'h14;
  wire  [7:0] mc   = motion_ctrl;
  wire  [4:0] gate = motion_event & ie_s[4:0]
                   & {mc[4] & mc[2], mc[3] & mc[2], mc[2], mc[0], mc[0]};
  wire        stall = md_s[4] && !serial_clk_pin || md_s[5] && serial_clk_pin;
  // Shadow bytes, since stored values are not visible at the ports
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ie_s <= 8'h00;
      md_s <= 8'h00;
      sr_s <= 8'h00;
    end else if (reg_wr) begin
      if (reg_addr == 8'h06) ie_s <= reg_wdata;
      if (reg_addr == 8'h07) md_s <= reg_wdata;
      if (reg_addr == 8'h08) sr_s <= reg_wdata;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence wr_mode_s; reg_wr && reg_addr == 8'h07; endsequence
  sequence wr_rate_s; reg_wr && reg_addr == 8'h08; endsequence
  rate_follow_a: assert property (
    wr_rate_s |-> ##2 osc_rate_code == sr_s[2:0]) else $error("rate code wrong");
  run_follow_a: assert property (
    wr_mode_s |-> ##2 osc_run == (md_s[1:0] != 2'b00)) else $error("run level wrong");
  wake_only_a: assert property (
    sample_strobe |-> md_s[1:0] == 2'b01 || $past(md_s[1:0]) == 2'b01
      || $past(md_s[1:0], 2) == 2'b01 || $past(md_s[1:0], 3) == 2'b01) else $error("bad sample");
  gated_set_a: assert property (
    ($past(gate, 2) & ~irq_status[4:0]) == 5'h00) else $error("event not reported");
  gated_only_a: assert property (
    (irq_status[4:0] & ~$past(irq_status[4:0]) & ~$past(gate, 2)) == 5'h00) else $error("gated");
  status_hold_a: assert property (
    ($past(irq_status[4:0]) & ~irq_status[4:0]) != 5'h00 |-> $past(wr14) || $past(wr14, 2)
      || $past(ie_s[6]) || $past(ie_s[6], 2)) else $error("status dropped");
  acq_set_a: assert property (
    sample_strobe && ie_s[7] |-> ##[1:2] irq_status[7]) else $error("sample flag missing");
  wdt_cause_a: assert property (
    slave_idle_req |-> $past(stall, 8) && $past(stall, 12)) else $error("timeout unstalled");
endmodule // aimrc_ctrl_checker
bind aimrc_ctrl aimrc_ctrl_checker #(.WDT_CYCLES(WDT_CYCLES), .CLK_HZ(CLK_HZ))
  aimrc_ctrl_checker_i (.*);
`default_nettype wire

//--- dv/aimrc_host.sv
/* Host model on the register port; assumes the bench calls its tasks. */
`timescale 1ns/1ps
`default_nettype none
module aimrc_host (
  input  wire logic       core_clk,
  input  wire logic [7:0] reg_rdata,
  output var  logic       reg_wr = 1'b0,
  output var  logic       reg_rd = 1'b0,
  output var  logic [7:0] reg_addr = 8'h00,
  output var  logic [7:0] reg_wdata = 8'h00
);
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= (a == 8'h07) ? d & 8'hF3 : (a == 8'h08) ? {5'h01, d[2:0]} : d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  // Read data is taken one edge after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(posedge core_clk);
    q = reg_rdata;
  endtask
endmodule // aimrc_host
`default_nettype wire
